// >>> design/fce_top.sv
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fce_cfg.svh"
module fce_top (
    // clock, reset, enable
    input  wire logic             core_clk,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    // axi4-lite write
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // fault reports
    input  wire logic             flt_valid,
    input  wire fce_pkg::fce_cause_t flt_cause,
    input  wire logic [31:0]      flt_addr,
    input  wire logic             flt_addr_ok,
    input  wire logic             xn_exec,
    input  wire logic [31:0]      xn_addr,
    input  wire logic             bad_isa,
    input  wire logic             cont_ret_bad,
    // execution context
    input  wire fce_pkg::fce_hnd_t ctx_hnd,
    input  wire logic [8:0]       ctx_prio,
    input  wire logic             bus_entry,
    input  wire logic             nmi_req,
    input  wire logic             dbg_halt,
    // exception request to pipeline
    output logic                  exc_req,
    output fce_pkg::fce_hnd_t     exc_hnd,
    input  wire logic             exc_ack,
    input  wire fce_pkg::fce_hnd_t exc_ack_hnd,
    output logic                  lockup
);
    import fce_pkg::*;

    logic              ev_val;
    fce_cause_t        ev_cause;
    logic [31:0]       ev_addr;
    logic              ev_addr_ok;
    fce_hnd_t          ev_cls;
    logic [2:0]        ev_bit;
    logic [7:0]        ev_hot;
    logic [8:0]        cls_prio;
    logic              cls_cfg;
    logic              cls_en;
    logic              exempt;
    logic              escalate;
    logic              hard_evt;
    logic              lock_hit;
    logic              cap_mem;
    logic              cap_bus;
    logic [23:0]       shpri;
    logic [2:0]        shctl;
    logic [31:0]       paddr;
    logic [31:0]       baddr;
    fce_lock_t         lock_st;
    fce_lock_t         next_lock;
    logic              aw_go;
    logic              ar_go;
    logic              wr_hit;
    logic [7:0]        w1c;
    logic [31:0]       wmask;
    logic [4:0]        pend_live;
    logic              win_any;
    fce_hnd_t          win_hnd;
    logic [8:0]        win_prio;

    fce_flag_if #(.W(8)) hard_if ();
    fce_flag_if #(.W(8)) prot_if ();
    fce_flag_if #(.W(8)) bus_if ();
    fce_flag_if #(.W(8)) use_if ();
    fce_flag_if #(.W(5)) pend_if ();

    // direct report, non-executable fetch and invalid state sources
    // a direct report wins; at most one event per cycle
    always_comb begin
        ev_val     = flt_valid | xn_exec | bad_isa | cont_ret_bad;
        ev_cause   = flt_cause;
        ev_addr    = flt_addr;
        ev_addr_ok = flt_addr_ok;
        if (!flt_valid && xn_exec) begin
            ev_cause   = FCE_C_IACC;
            ev_addr    = xn_addr;
            ev_addr_ok = 1'b1;
        end else if (!flt_valid) begin
            ev_cause   = FCE_C_BADSTATE;
            ev_addr_ok = 1'b0;
        end
    end

    always_comb begin
        unique case (ev_cause)
            FCE_C_TABLE_FETCH_ERROR_FLAG:     begin ev_cls = FCE_H_HARD;  ev_bit = `FCE_B_TABLE_FETCH_ERROR_FLAG;     end
            FCE_C_IACC:     begin ev_cls = FCE_H_MEM;   ev_bit = `FCE_B_IACC;     end
            FCE_C_DACC:     begin ev_cls = FCE_H_MEM;   ev_bit = `FCE_B_DACC;     end
            FCE_C_MPUSH:    begin ev_cls = FCE_H_MEM;   ev_bit = `FCE_B_MPUSH;    end
            FCE_C_MPOP:     begin ev_cls = FCE_H_MEM;   ev_bit = `FCE_B_MPOP;     end
            FCE_C_BPUSH:    begin ev_cls = FCE_H_BUS;   ev_bit = `FCE_B_BPUSH;    end
            FCE_C_BPOP:     begin ev_cls = FCE_H_BUS;   ev_bit = `FCE_B_BPOP;     end
            FCE_C_PREF:     begin ev_cls = FCE_H_BUS;   ev_bit = `FCE_B_PREF;     end
            FCE_C_PRECISE:  begin ev_cls = FCE_H_BUS;   ev_bit = `FCE_B_PRECISE;  end
            FCE_C_DEFERRED_DATA_BUS_ERROR_FLAG:    begin ev_cls = FCE_H_BUS;   ev_bit = `FCE_B_DEFERRED_DATA_BUS_ERROR_FLAG;    end
            FCE_C_COPROCESSOR_ACCESS_FLAG:     begin ev_cls = FCE_H_USAGE; ev_bit = `FCE_B_COPROCESSOR_ACCESS_FLAG;     end
            FCE_C_ILLEGAL_OPCODE_FLAG:    begin ev_cls = FCE_H_USAGE; ev_bit = `FCE_B_ILLEGAL_OPCODE_FLAG;    end
            FCE_C_BADSTATE: begin ev_cls = FCE_H_USAGE; ev_bit = `FCE_B_BADSTATE; end
            FCE_C_BADRET:   begin ev_cls = FCE_H_USAGE; ev_bit = `FCE_B_BADRET;   end
            FCE_C_MISALIGNED_ACCESS_FLAG:  begin ev_cls = FCE_H_USAGE; ev_bit = `FCE_B_MISALIGNED_ACCESS_FLAG;  end
            FCE_C_ZERO_DIVISOR_FLAG:     begin ev_cls = FCE_H_USAGE; ev_bit = `FCE_B_ZERO_DIVISOR_FLAG;     end
        endcase
    end

    assign ev_hot = ev_val ? (8'h01 << ev_bit) : 8'h00;

    always_comb begin
        cls_prio = `FCE_PRIO_HARD;
        cls_en   = 1'b1;
        cls_cfg  = 1'b1;
        unique case (ev_cls)
            FCE_H_MEM: begin
                cls_prio = {1'b0, shpri[7:0]} + `FCE_PRIO_BASE;
                cls_en   = shctl[0];
            end
            FCE_H_BUS: begin
                cls_prio = {1'b0, shpri[15:8]} + `FCE_PRIO_BASE;
                cls_en   = shctl[1];
            end
            FCE_H_USAGE: begin
                cls_prio = {1'b0, shpri[23:16]} + `FCE_PRIO_BASE;
                cls_en   = shctl[2];
            end
            default: cls_cfg = 1'b0;
        endcase
    end

    assign exempt = (ev_cause == FCE_C_BPUSH) && bus_entry;

    // escalation
    // numerically larger or equal means not higher priority
    assign escalate = ev_val && cls_cfg && !exempt
        && ((ctx_hnd == ev_cls)
            || (ctx_hnd != FCE_H_NONE && cls_prio >= ctx_prio)
            || !cls_en);

    assign hard_evt = ev_val && (ev_cls == FCE_H_HARD || escalate);

    // hard fault in nmi or hard
    assign lock_hit = hard_evt
        && (ctx_hnd == FCE_H_NMI || ctx_hnd == FCE_H_HARD);

    // first address kept
    // later faults do not overwrite an address until its valid bit is cleared by a write
    assign cap_mem = ev_val && ev_cls == FCE_H_MEM && ev_addr_ok
        && !prot_if.q[`FCE_B_AVALID];
    assign cap_bus = ev_val && ev_cls == FCE_H_BUS && ev_addr_ok
        && !bus_if.q[`FCE_B_AVALID];

    assign hard_if.set = (ev_cls == FCE_H_HARD ? ev_hot : 8'h00)
        | (escalate ? (8'h01 << `FCE_B_FORCED) : 8'h00);
    assign prot_if.set = (ev_cls == FCE_H_MEM ? ev_hot : 8'h00)
        | (cap_mem ? (8'h01 << `FCE_B_AVALID) : 8'h00);
    assign bus_if.set  = (ev_cls == FCE_H_BUS ? ev_hot : 8'h00)
        | (cap_bus ? (8'h01 << `FCE_B_AVALID) : 8'h00);
    assign use_if.set  = ev_cls == FCE_H_USAGE ? ev_hot : 8'h00;

    assign w1c         = s_axi_wdata[7:0] & {8{s_axi_wstrb[0]}};
    assign hard_if.clr = (aw_go && s_axi_awaddr == `FCE_OFF_HARD)
        ? w1c : 8'h00;
    assign prot_if.clr = (aw_go && s_axi_awaddr == `FCE_OFF_PROT)
        ? w1c : 8'h00;
    assign bus_if.clr  = (aw_go && s_axi_awaddr == `FCE_OFF_BUS)
        ? w1c : 8'h00;
    assign use_if.clr  = (aw_go && s_axi_awaddr == `FCE_OFF_USAGE)
        ? w1c : 8'h00;

    // pending: bit0 nmi, bit1 hard, bit2..4 mem, bus, usage
    // no nmi pended while locked from nmi
    always_comb begin
        pend_if.set    = '0;
        pend_if.set[0] = nmi_req && lock_st != FCE_LK_NMI;
        pend_if.set[1] = hard_evt && !lock_hit;
        if (ev_val && cls_cfg && !escalate) begin
            // mem, bus, usage codes 3..5 map to pending bits 2..4
            pend_if.set[3'(ev_cls) - 3'd1] = 1'b1;
        end
        pend_if.clr = '0;
        if (exc_ack && exc_ack_hnd != FCE_H_NONE
                && exc_ack_hnd != FCE_H_OTHER) begin
            pend_if.clr[3'(exc_ack_hnd) - 3'd1] = 1'b1;
        end
    end

    fce_sticky #(.W(8)) u_hard (
        .core_clk (core_clk), .sys_rst (sys_rst), .ce (ce), .f (hard_if));
    fce_sticky #(.W(8)) u_prot (
        .core_clk (core_clk), .sys_rst (sys_rst), .ce (ce), .f (prot_if));
    fce_sticky #(.W(8)) u_bus (
        .core_clk (core_clk), .sys_rst (sys_rst), .ce (ce), .f (bus_if));
    fce_sticky #(.W(8)) u_use (
        .core_clk (core_clk), .sys_rst (sys_rst), .ce (ce), .f (use_if));
    fce_sticky #(.W(5)) u_pend (
        .core_clk (core_clk), .sys_rst (sys_rst), .ce (ce), .f (pend_if));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            paddr <= 32'h0000_0000;
            baddr <= 32'h0000_0000;
        end else if (ce) begin
            if (cap_mem) begin
                paddr <= ev_addr;
            end
            if (cap_bus) begin
                baddr <= ev_addr;
            end
        end
    end

    always_comb begin
        next_lock = lock_st;
        unique case (lock_st)
            FCE_LK_RUN: begin
                if (lock_hit) begin
                    next_lock = (ctx_hnd == FCE_H_NMI)
                        ? FCE_LK_NMI : FCE_LK_HARD;
                end
            end
            FCE_LK_HARD: begin
                if (nmi_req || dbg_halt) begin
                    next_lock = FCE_LK_RUN;
                end
            end
            FCE_LK_NMI: begin
                if (dbg_halt) begin
                    next_lock = FCE_LK_RUN;
                end
            end
            default: next_lock = FCE_LK_RUN;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lock_st <= FCE_LK_RUN;
        end else if (ce) begin
            lock_st <= next_lock;
        end
    end

    assign lockup = lock_st != FCE_LK_RUN;

    // ack masks its own bit so the request drops at once
    assign pend_live = pend_if.q & ~pend_if.clr;

    fce_arb u_arb (
        .pend     (pend_live),
        .prio_cfg (shpri),
        .win_any  (win_any),
        .win_hnd  (win_hnd),
        .win_prio (win_prio)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            exc_req <= 1'b0;
            exc_hnd <= FCE_H_NONE;
        end else if (ce) begin
            exc_req <= win_any && next_lock == FCE_LK_RUN
                && (ctx_hnd == FCE_H_NONE || win_prio < ctx_prio);
            exc_hnd <= win_hnd;
        end
    end

    // write channel: both halves taken in one edge
    assign aw_go = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = aw_go;
    assign s_axi_wready  = aw_go;
    assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};

    always_comb begin
        unique case (s_axi_awaddr)
            `FCE_OFF_HARD, `FCE_OFF_PROT, `FCE_OFF_BUS,
            `FCE_OFF_USAGE, `FCE_OFF_PADDR, `FCE_OFF_BADDR,
            `FCE_OFF_SHPRI, `FCE_OFF_SHCTL,
            `FCE_OFF_STAT: wr_hit = 1'b1;
            default:       wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            shpri <= `FCE_RST_SHPRI;
            shctl <= `FCE_RST_SHCTL;
        end else if (aw_go) begin
            if (s_axi_awaddr == `FCE_OFF_SHPRI) begin
                shpri <= (shpri & ~wmask[23:0])
                    | (s_axi_wdata[23:0] & wmask[23:0]);
            end
            if (s_axi_awaddr == `FCE_OFF_SHCTL && s_axi_wstrb[0]) begin
                shctl <= s_axi_wdata[2:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `FCE_RESP_OKAY;
        end else if (ce) begin
            if (aw_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `FCE_RESP_OKAY
                                       : `FCE_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel: data one cycle after address
    assign ar_go = ce && s_axi_arvalid && !s_axi_rvalid;
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `FCE_RESP_OKAY;
        end else if (ce) begin
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `FCE_RESP_OKAY;
                unique case (s_axi_araddr)
                    `FCE_OFF_HARD:  s_axi_rdata <= {24'h00_0000, hard_if.q};
                    `FCE_OFF_PROT:  s_axi_rdata <= {24'h00_0000, prot_if.q};
                    `FCE_OFF_BUS:   s_axi_rdata <= {24'h00_0000, bus_if.q};
                    `FCE_OFF_USAGE: s_axi_rdata <= {24'h00_0000, use_if.q};
                    `FCE_OFF_PADDR: s_axi_rdata <= paddr;
                    `FCE_OFF_BADDR: s_axi_rdata <= baddr;
                    `FCE_OFF_SHPRI: s_axi_rdata <= {8'h00, shpri};
                    `FCE_OFF_SHCTL: s_axi_rdata <= {29'h0, shctl};
                    `FCE_OFF_STAT:  s_axi_rdata <= {27'h0, pend_if.q[4:2],
                        lock_st == FCE_LK_NMI, lockup};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `FCE_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    chk_table_fetch_error_flag_flag: assert property (
        ce && ev_val && ev_cause == FCE_C_TABLE_FETCH_ERROR_FLAG
        |=> hard_if.q[`FCE_B_TABLE_FETCH_ERROR_FLAG])
        else $error("vector read error not flagged");

    chk_forced_flag: assert property (
        ce && escalate |=> hard_if.q[`FCE_B_FORCED] && lockup == $past(lock_hit)
            || hard_if.q[`FCE_B_FORCED] && pend_if.q[1])
        else $error("escalation not recorded");

    chk_mem_route: assert property (
        ce && ev_val && ev_cls == FCE_H_MEM && !escalate
        |=> pend_if.q[2] && prot_if.q[$past(ev_bit)])
        else $error("protection fault not routed");

    chk_xn_flag: assert property (
        ce && xn_exec && !flt_valid
        |=> prot_if.q[`FCE_B_IACC])
        else $error("non-executable fetch not flagged");

    chk_disabled_esc: assert property (
        ce && ev_val && cls_cfg && !cls_en && !exempt
        |-> escalate && !pend_if.set[3'(ev_cls) - 3'd1])
        else $error("disabled handler fault not escalated");

    chk_bus_push: assert property (
        ce && ev_val && exempt |-> !escalate ##1 pend_if.q[3])
        else $error("bus handler entry error escalated");

    chk_lock_nmi: assert property (
        ce && lock_hit && ctx_hnd == FCE_H_NMI
        |=> lock_st == FCE_LK_NMI ##1 (lockup || $past(dbg_halt && ce)))
        else $error("lockup from nmi handler missed");

    chk_nmi_ignored: assert property (
        lock_st == FCE_LK_NMI && !dbg_halt |=> lockup)
        else $error("nmi released nmi lockup");

    chk_no_req_lock: assert property (
        ce && next_lock != FCE_LK_RUN |=> !exc_req)
        else $error("request while locked");

    chk_addr_hold: assert property (
        prot_if.q[`FCE_B_AVALID] && prot_if.clr == 8'h00
        |=> $stable(paddr))
        else $error("captured address changed");

    cov_lock_hard: cover property (ce && lock_hit && ctx_hnd == FCE_H_HARD);
    cov_escalate:  cover property (ce && escalate ##[1:20] exc_req);
    cov_exempt:    cover property (ce && ev_val && exempt);
endmodule : fce_top
`default_nettype wire

// >>> inc/fce_cfg.svh
`ifndef FCE_CFG_SVH
`define FCE_CFG_SVH

`define FCE_AW          8
`define FCE_OFF_HARD    8'h00
`define FCE_OFF_PROT    8'h04
`define FCE_OFF_BUS     8'h08
`define FCE_OFF_USAGE   8'h0C
`define FCE_OFF_PADDR   8'h10
`define FCE_OFF_BADDR   8'h14
`define FCE_OFF_SHPRI   8'h18
`define FCE_OFF_SHCTL   8'h1C
`define FCE_OFF_STAT    8'h20

`define FCE_B_TABLE_FETCH_ERROR_FLAG      3'd0
`define FCE_B_FORCED    3'd1
`define FCE_B_IACC      3'd0
`define FCE_B_DACC      3'd1
`define FCE_B_MPUSH     3'd2
`define FCE_B_MPOP      3'd3
`define FCE_B_BPUSH     3'd0
`define FCE_B_BPOP      3'd1
`define FCE_B_PREF      3'd2
`define FCE_B_PRECISE   3'd3
`define FCE_B_DEFERRED_DATA_BUS_ERROR_FLAG     3'd4
`define FCE_B_COPROCESSOR_ACCESS_FLAG      3'd0
`define FCE_B_ILLEGAL_OPCODE_FLAG     3'd1
`define FCE_B_BADSTATE  3'd2
`define FCE_B_BADRET    3'd3
`define FCE_B_MISALIGNED_ACCESS_FLAG   3'd4
`define FCE_B_ZERO_DIVISOR_FLAG      3'd5
`define FCE_B_AVALID    3'd7

`define FCE_RST_SHPRI   24'h00_0000
`define FCE_RST_SHCTL   3'h0
`define FCE_PRIO_NMI    9'h000
`define FCE_PRIO_HARD   9'h001
`define FCE_PRIO_BASE   9'h002
`define FCE_RESP_OKAY   2'h0
`define FCE_RESP_SLVERR 2'h2

`endif

// >>> inc/fce_pkg.sv
package fce_pkg;
    typedef enum logic [3:0] {
        FCE_C_TABLE_FETCH_ERROR_FLAG, FCE_C_IACC, FCE_C_DACC, FCE_C_MPUSH,
        FCE_C_MPOP, FCE_C_BPUSH, FCE_C_BPOP, FCE_C_PREF,
        FCE_C_PRECISE, FCE_C_DEFERRED_DATA_BUS_ERROR_FLAG, FCE_C_COPROCESSOR_ACCESS_FLAG, FCE_C_ILLEGAL_OPCODE_FLAG,
        FCE_C_BADSTATE, FCE_C_BADRET, FCE_C_MISALIGNED_ACCESS_FLAG, FCE_C_ZERO_DIVISOR_FLAG
    } fce_cause_t;

    typedef enum logic [2:0] {
        FCE_H_NONE  = 3'h0,
        FCE_H_NMI   = 3'h1,
        FCE_H_HARD  = 3'h2,
        FCE_H_MEM   = 3'h3,
        FCE_H_BUS   = 3'h4,
        FCE_H_USAGE = 3'h5,
        FCE_H_OTHER = 3'h6
    } fce_hnd_t;

    typedef enum logic [2:0] {
        FCE_LK_RUN  = 3'b001,
        FCE_LK_HARD = 3'b010,
        FCE_LK_NMI  = 3'b100
    } fce_lock_t;
endpackage : fce_pkg

// >>> inc/fce_flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fce_flag_if #(parameter int W = 8);
    logic [W-1:0] set;
    logic [W-1:0] clr;
    logic [W-1:0] q;
    modport owner (input set, input clr, output q);
    modport user  (output set, output clr, input q);
endinterface : fce_flag_if
`default_nettype wire

// >>> design/fce_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module fce_sticky #(
    parameter int W = 8
) (
    // clock and control
    input  wire logic  core_clk,
    input  wire logic  sys_rst,
    input  wire logic  ce,
    // flag group
    fce_flag_if.owner  f
);
    logic [W-1:0] next_q;

    // hold until cleared
    // set beats clear so a same-cycle event is kept
    always_comb begin
        next_q = (f.q & ~f.clr) | f.set;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            f.q <= '0;
        end else if (ce) begin
            f.q <= next_q;
        end
    end
endmodule : fce_sticky
`default_nettype wire

// >>> design/fce_arb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fce_cfg.svh"
module fce_arb (
    // pending: nmi, hard, mem, bus, usage
    input  wire logic [4:0]  pend,
    input  wire logic [23:0] prio_cfg,
    // winner
    output logic             win_any,
    output fce_pkg::fce_hnd_t win_hnd,
    output logic [8:0]       win_prio
);
    import fce_pkg::*;

    // lowest number wins ties
    // scan runs in exception number order, strict compare
    always_comb begin
        logic [8:0] p;
        p        = '0;
        win_any  = 1'b0;
        win_hnd  = FCE_H_NONE;
        win_prio = '1;
        for (int i = 0; i < 5; i++) begin
            if (i == 0) begin
                p = `FCE_PRIO_NMI;
            end else if (i == 1) begin
                p = `FCE_PRIO_HARD;
            end else begin
                p = {1'b0, prio_cfg[(i-2)*8 +: 8]} + `FCE_PRIO_BASE;
            end
            if (pend[i] && (!win_any || p < win_prio)) begin
                win_any  = 1'b1;
                win_prio = p;
                win_hnd  = fce_hnd_t'(3'(i + 1));
            end
        end
    end
endmodule : fce_arb
`default_nettype wire

// >>> test/fce_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
// takes each request one cycle late, like a busy pipeline
module fce_pipe_model (
    // clock, reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // request, ack
    input  wire logic              exc_req,
    input  wire fce_pkg::fce_hnd_t exc_hnd,
    output logic                   exc_ack,
    output fce_pkg::fce_hnd_t      exc_ack_hnd
);
    import fce_pkg::*;
    always_ff @(posedge core_clk) begin
        exc_ack <= !sys_rst && exc_req && !exc_ack;
        // idle: no stale handler code
        exc_ack_hnd <= exc_req ? exc_hnd : FCE_H_OTHER;
    end
endmodule : fce_pipe_model
`default_nettype wire

// >>> test/test_fce_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "fce_cfg.svh"
module test_fce_top;
    import fce_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, ce = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [31:0] flt_addr = 32'h0000_0000, xn_addr = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, flt_addr_ok = 1'b0;
    logic cont_ret_bad = 1'b0, bus_entry = 1'b0;
    logic [4:0] kick = 5'h00;
    logic [8:0] ctx_prio = 9'h000;
    fce_cause_t flt_cause = FCE_C_TABLE_FETCH_ERROR_FLAG;
    fce_hnd_t ctx_hnd = FCE_H_NONE;
    fce_hnd_t exc_hnd, exc_ack_hnd;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, exc_req, exc_ack, lockup;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    wire logic flt_valid = kick[0];
    wire logic xn_exec = kick[1];
    wire logic bad_isa = kick[2];
    wire logic nmi_req = kick[3];
    wire logic dbg_halt = kick[4];
    int err_total = 0, n_tests = 0;

    fce_top fce_top_i (.*);
    fce_pipe_model fce_pipe_model_i (.*);

    initial forever #4 core_clk = ~core_clk;

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(negedge core_clk); while (!s_axi_awready);
        @(posedge core_clk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(negedge core_clk); while (!s_axi_bvalid);
        chk({32'h0000_0000, s_axi_bresp}, 34'h0_0000_0000);
        @(posedge core_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge core_clk); while (!s_axi_arready);
        @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge core_clk); while (!s_axi_rvalid);
        chk({s_axi_rresp, s_axi_rdata}, e);
        @(posedge core_clk);
    endtask : rd

    // one-cycle event pulse, then one quiet cycle
    task automatic hit(input logic [4:0] k);
        kick <= k;
        @(posedge core_clk);
        kick <= 5'h00;
        @(posedge core_clk);
    endtask : hit

    task automatic lk(input logic e);
        @(negedge core_clk);
        chk({33'h0_0000_0000, lockup}, {33'h0_0000_0000, e});
        @(posedge core_clk);
    endtask : lk

    task automatic final_report();
        if (err_total == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    initial begin
        #100_000;
        err_total++;
        final_report();
    end

    initial begin
        logic [7:0] o;
        int b;
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        rd(8'h40, 34'h2_0000_0000);
        wr(`FCE_OFF_SHPRI, 32'h0003_0201);
        rd(`FCE_OFF_SHPRI, 34'h0_0003_0201);
        wr(`FCE_OFF_SHCTL, 32'h0000_0007);
        for (int i = 0; i < 16; i++) begin
            o = i == 0 ? 8'h00 : i < 5 ? 8'h04 : i < 10 ? 8'h08 : 8'h0c;
            b = i == 0 ? 0 : i < 5 ? i - 1 : i < 10 ? i - 5 : i - 10;
            flt_cause <= fce_cause_t'(i);
            hit(5'h01);
            rd(o, 34'h0_0000_0001 << b);
            wr(o, 32'h0000_00ff);
            rd(o, 34'h0_0000_0000);
        end
        xn_addr <= 32'h0000_7ff0;
        hit(5'h02);
        @(negedge core_clk);
        chk({30'h0, exc_req, exc_hnd}, {30'h0, 1'b1, FCE_H_MEM});
        @(posedge core_clk);
        rd(`FCE_OFF_PROT, 34'h0_0000_0081);
        flt_cause <= FCE_C_DACC;
        flt_addr <= 32'h2000_0040;
        flt_addr_ok <= 1'b1;
        hit(5'h01);
        rd(`FCE_OFF_PROT, 34'h0_0000_0083);
        rd(`FCE_OFF_PADDR, 34'h0_0000_7ff0);
        flt_cause <= FCE_C_PRECISE;
        hit(5'h01);
        rd(`FCE_OFF_BADDR, 34'h0_2000_0040);
        hit(5'h04);
        rd(`FCE_OFF_USAGE, 34'h0_0000_0004);
        wr(`FCE_OFF_SHCTL, 32'h0000_0000);
        bus_entry <= 1'b1;
        flt_cause <= FCE_C_BPUSH;
        hit(5'h01);
        bus_entry <= 1'b0;
        rd(`FCE_OFF_HARD, 34'h0_0000_0000);
        rd(`FCE_OFF_BUS, 34'h0_0000_0089);
        flt_cause <= FCE_C_ILLEGAL_OPCODE_FLAG;
        hit(5'h01);
        rd(`FCE_OFF_HARD, 34'h0_0000_0002);
        wr(`FCE_OFF_SHCTL, 32'h0000_0007);
        wr(`FCE_OFF_HARD, 32'h0000_00ff);
        ctx_hnd <= FCE_H_OTHER;
        ctx_prio <= 9'h004;
        flt_cause <= FCE_C_PRECISE;
        hit(5'h01);
        rd(`FCE_OFF_HARD, 34'h0_0000_0002);
        wr(`FCE_OFF_HARD, 32'h0000_00ff);
        ctx_hnd <= FCE_H_BUS;
        flt_cause <= FCE_C_DACC;
        hit(5'h01);
        rd(`FCE_OFF_HARD, 34'h0_0000_0000);
        flt_cause <= FCE_C_ILLEGAL_OPCODE_FLAG;
        hit(5'h01);
        rd(`FCE_OFF_HARD, 34'h0_0000_0002);
        wr(`FCE_OFF_HARD, 32'h0000_00ff);
        ctx_hnd <= FCE_H_MEM;
        ctx_prio <= 9'h1f0;
        flt_cause <= FCE_C_DACC;
        hit(5'h01);
        rd(`FCE_OFF_HARD, 34'h0_0000_0002);
        ctx_hnd <= FCE_H_HARD;
        flt_cause <= FCE_C_TABLE_FETCH_ERROR_FLAG;
        hit(5'h01);
        lk(1'b1);
        hit(5'h08);
        lk(1'b0);
        ctx_hnd <= FCE_H_NMI;
        hit(5'h01);
        hit(5'h08);
        lk(1'b1);
        rd(`FCE_OFF_STAT, 34'h0_0000_0003);
        hit(5'h10);
        lk(1'b0);
        final_report();
    end
endmodule : test_fce_top
`default_nettype wire
